/* hw/ass_seq.sv */
/*
  multi-segment playback sequencer with an axi4-lite register slave.
  assumes segment table (start, length, file id) and play list are written
  by software before playback; sample addresses go to the waveform memory.
*/
// How it works
// RULE1 - every next-segment event switches output to the following segment
// RULE2 - after the last segment an event wraps to the first segment
// RULE3 - status shows current segment index and its file identity
// RULE4 - internal source advances only on the execute-next command
// RULE5 - writing segment-select with internal source jumps straight there
// RULE6 - external source listens only on the configured user connector
// RULE7 - default order is ascending from the first segment
// RULE8 - manual triggering takes the next index from the next-segment setting
// RULE9 - play-list order takes next indices from list entries
// RULE10 - immediate mode aborts current segment and starts next at once
// RULE11 - seamless mode finishes current segment before starting next
// RULE12 - seamless mode only when all segments share one clock rate
// RULE13 - sequence start/stop kept separate from next-segment path
// RULE14 - next-segment controls act only while multi-segment file loaded
// RULE15 - external event acts exactly like the internal command; in ASS_ORD_NEXT order it steps ascending, ignoring next_q
// RULE16 - play list usable only after the file is created
// RULE17 - play list usable only with more than one segment
// RULE18 - marker rises at each segment start, also on replay
// RULE19 - each new segment starts from its first sample
// RULE20 - events during a pending seamless switch keep it, latest index
`timescale 1ns/100ps
`include "ass_defines.svh"
module ass_seq (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [1:0] user_conn,
  output logic [31:0] sample_addr,
  output logic sample_valid,
  output logic seg_begin_marker
);
  import ass_pkg::*;
  localparam int NS = `ASS_NSEG;
  logic [31:0] ctrl_q;
  ass_seg_t segsel_q, next_q, nseg_q, pllen_q;
  logic [31:0] seg_start_q [NS];
  ass_len_t seg_len_q [NS];
  logic [`ASS_FILE_W-1:0] seg_file_q [NS];
  ass_seg_t pl_q [`ASS_PL_DEPTH];
  ass_seg_t cur_q, pend_q, plpos_q;
  ass_len_t pos_q;
  ass_state_e st_q;
  logic marker_q;
  logic [11:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic aw_have_q, w_have_q;
  logic cmd_next, cmd_start, cmd_stop, segsel_wr;
  logic wr_go;
  logic [11:0] wa;
  logic [31:0] rd_d;
  logic rd_ok;
  logic loaded, ext_src, seamless, pl_ok, nxt_ev, seg_end;
  ass_order_e order;
  ass_seg_t foll, last_seg;
  ass_trig_if tif ();

  assign tif.conn_raw = user_conn;
  assign tif.conn_sel = ctrl_q[`ASS_CTRL_CONN];
  assign tif.enable = loaded && ext_src; // [RULE14]
  ass_ext_trig u_trig (
    .aclk(aclk),
    .aresetn(aresetn),
    .tif(tif)
  );

  // write channel: address and data taken in either order
  assign s_axi_awready = !aw_have_q && !s_axi_bvalid;
  assign s_axi_wready = !w_have_q && !s_axi_bvalid;
  assign wr_go = aw_have_q && w_have_q;
  assign wa = awaddr_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awaddr_q <= 12'h000;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `ASS_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (wa[11:8] <= 4'h2 && !(wa[11:8] == 4'h0 &&
          wa[7:0] > `ASS_REG_PLLEN)) ? `ASS_RESP_OKAY : `ASS_RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // register file; a write with no byte enable for lane 0 is dropped
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= `ASS_CTRL_RESET;
      segsel_q <= '0;
      next_q <= '0;
      nseg_q <= '0;
      pllen_q <= '0;
    end else if (wr_go && wstrb_q[0]) begin
      unique case (wa)
        `ASS_REG_CTRL: ctrl_q <= {24'h00_0000, wdata_q[7:0]};
        `ASS_REG_SEGSEL: segsel_q <= wdata_q[`ASS_SEG_W-1:0];
        `ASS_REG_NEXT: next_q <= wdata_q[`ASS_SEG_W-1:0];
        `ASS_REG_NSEG: nseg_q <= wdata_q[`ASS_SEG_W-1:0];
        `ASS_REG_PLLEN: pllen_q <= wdata_q[`ASS_SEG_W-1:0];
        default: ;
      endcase
    end
  end

  // segment table: 4 words per entry (start, length, file id, spare)
  always_ff @(posedge aclk) begin
    if (wr_go && wa[11:8] == 4'h1) begin
      unique case (wa[3:2])
        2'd0: seg_start_q[wa[7:4]] <= wdata_q;
        2'd1: seg_len_q[wa[7:4]] <= wdata_q[`ASS_LEN_W-1:0];
        2'd2: seg_file_q[wa[7:4]] <= wdata_q[`ASS_FILE_W-1:0];
        default: ;
      endcase
    end
    if (wr_go && wa[11:8] == 4'h2 && wa[7:6] == 2'b00)
      pl_q[wa[5:2]] <= wdata_q[`ASS_PL_W-1:0];
  end

  assign cmd_next = wr_go && wstrb_q[0] && wa == `ASS_REG_CMD &&
    wdata_q[`ASS_CMD_NEXT];
  assign cmd_start = wr_go && wstrb_q[0] && wa == `ASS_REG_CMD &&
    wdata_q[`ASS_CMD_START];
  assign cmd_stop = wr_go && wstrb_q[0] && wa == `ASS_REG_CMD &&
    wdata_q[`ASS_CMD_STOP];
  assign segsel_wr = wr_go && wstrb_q[0] && wa == `ASS_REG_SEGSEL;

  // read channel
  always_comb begin
    rd_d = 32'h0000_0000;
    rd_ok = 1'b1;
    if (s_axi_araddr[11:8] == 4'h1) begin
      unique case (s_axi_araddr[3:2])
        2'd0: rd_d = seg_start_q[s_axi_araddr[7:4]];
        2'd1: rd_d = {16'h0000, seg_len_q[s_axi_araddr[7:4]]};
        2'd2: rd_d = {24'h00_0000, seg_file_q[s_axi_araddr[7:4]]};
        default: rd_d = 32'h0000_0000;
      endcase
    end else if (s_axi_araddr[11:8] == 4'h2 &&
      s_axi_araddr[7:6] == 2'b00) begin
      rd_d = {28'h000_0000, pl_q[s_axi_araddr[5:2]]};
    end else begin
      unique case (s_axi_araddr)
        `ASS_REG_CTRL: rd_d = ctrl_q;
        `ASS_REG_SEGSEL: rd_d = {28'h000_0000, segsel_q};
        `ASS_REG_NEXT: rd_d = {28'h000_0000, next_q};
        `ASS_REG_CMD: rd_d = 32'h0000_0000;
        // index, file identity, state and pending flag [RULE3]
        `ASS_REG_STATUS: rd_d = {12'h000, pl_ok, st_q == ASS_ST_PEND,
          st_q != ASS_ST_IDLE, 1'b0, seg_file_q[cur_q], 4'h0, cur_q};
        `ASS_REG_NSEG: rd_d = {28'h000_0000, nseg_q};
        `ASS_REG_PLLEN: rd_d = {28'h000_0000, pllen_q};
        default: rd_ok = 1'b0;
      endcase
    end
  end
  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `ASS_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_d;
      s_axi_rresp <= rd_ok ? `ASS_RESP_OKAY : `ASS_RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // sequencing decisions
  assign loaded = ctrl_q[`ASS_CTRL_LOADED];
  assign ext_src = ctrl_q[`ASS_CTRL_EXTSRC];
  // seamless only honoured with equal clock rates [RULE12]
  assign seamless = ctrl_q[`ASS_CTRL_SEAMLESS] && ctrl_q[`ASS_CTRL_EQCLK];
  assign order = ass_order_e'(ctrl_q[`ASS_CTRL_ORDER_HI:`ASS_CTRL_ORDER_LO]);
  // play list needs a created file and two or more segments
  assign pl_ok = ctrl_q[`ASS_CTRL_CREATED] && // [RULE16]
    nseg_q > 4'd1 && pllen_q != 4'd0; // [RULE17]
  // internal command or external edge, same effect except in ASS_ORD_NEXT, where only the command takes next_q [RULE4] [RULE15]
  assign nxt_ev = loaded && st_q != ASS_ST_IDLE &&
    (ext_src ? tif.ext_event : cmd_next); // [RULE14]
  assign last_seg = nseg_q - 4'd1;
  assign seg_end = pos_q == seg_len_q[cur_q] - 16'd1 ||
    seg_len_q[cur_q] == 16'd0;
  always_comb begin
    // ascending with wrap [RULE1] [RULE2] [RULE7]
    foll = (cur_q >= last_seg) ? 4'd0 : cur_q + 4'd1;
    if (order == ASS_ORD_NEXT && !ext_src)
      foll = next_q; // [RULE8]
    else if (order == ASS_ORD_LIST && pl_ok)
      foll = pl_q[plpos_q]; // [RULE9]
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q <= ASS_ST_IDLE;
      cur_q <= '0;
      pend_q <= '0;
      pos_q <= '0;
      plpos_q <= '0;
      marker_q <= 1'b0;
    end else begin
      marker_q <= 1'b0;
      unique case (st_q)
        ASS_ST_IDLE: begin
          // sequence start from its own start command, apart from the next-segment path [RULE13]
          if (cmd_start && loaded) begin
            st_q <= ASS_ST_PLAY;
            cur_q <= '0; // [RULE7]
            pos_q <= '0;
            plpos_q <= '0;
            marker_q <= 1'b1;
          end
        end
        ASS_ST_PLAY, ASS_ST_PEND: begin
          if (cmd_stop || !loaded) begin
            st_q <= ASS_ST_IDLE; // [RULE13]
          end else if (segsel_wr && !ext_src) begin
            // segsel_q only takes the value on this same edge
            cur_q <= wdata_q[`ASS_SEG_W-1:0]; // [RULE5]
            pos_q <= '0;
            marker_q <= 1'b1;
            st_q <= ASS_ST_PLAY;
          end else if (nxt_ev && !seamless) begin
            cur_q <= foll; // [RULE10]
            pos_q <= '0; // [RULE19]
            marker_q <= 1'b1; // [RULE18]
            if (order == ASS_ORD_LIST && pl_ok)
              plpos_q <= (plpos_q >= pllen_q - 4'd1) ? 4'd0 : plpos_q + 4'd1;
            st_q <= ASS_ST_PLAY;
          end else if (seg_end) begin
            pos_q <= '0; // [RULE19]
            marker_q <= 1'b1; // [RULE18]
            if (st_q == ASS_ST_PEND || (nxt_ev && seamless)) begin
              cur_q <= (nxt_ev && seamless) ? foll : pend_q; // [RULE11]
              st_q <= ASS_ST_PLAY;
            end
          end else begin
            pos_q <= pos_q + 16'd1;
            if (nxt_ev && seamless) begin
              pend_q <= foll; // [RULE20]
              st_q <= ASS_ST_PEND; // [RULE11]
              if (st_q == ASS_ST_PLAY && order == ASS_ORD_LIST && pl_ok)
                plpos_q <= (plpos_q >= pllen_q - 4'd1) ? 4'd0 :
                  plpos_q + 4'd1;
            end
          end
        end
        default: st_q <= ASS_ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sample_addr <= 32'h0000_0000;
      sample_valid <= 1'b0;
      seg_begin_marker <= 1'b0;
    end else begin
      sample_addr <= seg_start_q[cur_q] + {16'h0000, pos_q};
      sample_valid <= st_q != ASS_ST_IDLE;
      seg_begin_marker <= marker_q; // [RULE18]
    end
  end
endmodule

/* hw/ass_defines.svh */
/*
  constants of the segment sequencer: register offsets, field positions,
  reset values and sizes. assumes inclusion from package and modules.
*/
`ifndef ASS_DEFINES_SVH
`define ASS_DEFINES_SVH
`define ASS_SEG_W 4
`define ASS_NSEG 16
`define ASS_LEN_W 16
`define ASS_PL_DEPTH 16
`define ASS_PL_W 4
`define ASS_FILE_W 8
`define ASS_REG_CTRL 12'h000
`define ASS_REG_SEGSEL 12'h004
`define ASS_REG_NEXT 12'h008
`define ASS_REG_CMD 12'h00C
`define ASS_REG_STATUS 12'h010
`define ASS_REG_NSEG 12'h014
`define ASS_REG_PLLEN 12'h018
`define ASS_REG_SEGTAB 12'h100
`define ASS_REG_PLTAB 12'h200
`define ASS_CTRL_LOADED 0
`define ASS_CTRL_CREATED 1
`define ASS_CTRL_EXTSRC 2
`define ASS_CTRL_SEAMLESS 3
`define ASS_CTRL_ORDER_LO 4
`define ASS_CTRL_ORDER_HI 5
`define ASS_CTRL_CONN 6
`define ASS_CTRL_EQCLK 7
`define ASS_CTRL_RESET 32'h0000_0000
`define ASS_CMD_NEXT 0
`define ASS_CMD_START 1
`define ASS_CMD_STOP 2
`define ASS_RESP_OKAY 2'b00
`define ASS_RESP_SLVERR 2'b10
`endif

/* hw/ass_pkg.sv */
/*
  types of the segment sequencer. assumes ass_defines.svh is on the
  include path.
*/
package ass_pkg;
  `include "ass_defines.svh"
  typedef logic [`ASS_SEG_W-1:0] ass_seg_t;
  typedef logic [`ASS_LEN_W-1:0] ass_len_t;
  typedef enum logic [1:0] {
    ASS_ORD_INCR = 2'b00,
    ASS_ORD_NEXT = 2'b01,
    ASS_ORD_LIST = 2'b10
  } ass_order_e;
  typedef enum logic [1:0] {
    ASS_ST_IDLE = 2'b00,
    ASS_ST_PLAY = 2'b01,
    ASS_ST_PEND = 2'b11
  } ass_state_e;
endpackage

/* hw/ass_trig_if.sv */
/*
  interface between the sequencer and the external trigger filter.
  assumes one clock, aclk.
*/
`timescale 1ns/100ps
interface ass_trig_if;
  import ass_pkg::*;
  logic [1:0] conn_raw;
  logic conn_sel;
  logic enable;
  logic ext_event;
  modport filt (input conn_raw, input conn_sel, input enable,
    output ext_event);
  modport user (output conn_raw, output conn_sel, output enable,
    input ext_event);
endinterface

/* hw/ass_ext_trig.sv */
/*
  external next-segment trigger: synchronises both user connectors and
  emits a one-cycle pulse on a rising edge of the selected one.
  assumes connectors are asynchronous to aclk.
*/
`timescale 1ns/100ps
module ass_ext_trig (
  input wire logic aclk,
  input wire logic aresetn,
  ass_trig_if.filt tif
);
  import ass_pkg::*;
  logic [1:0] s1_q;
  logic [1:0] s2_q;
  logic [1:0] s3_q;
  genvar i;
  generate
    for (i = 0; i < 2; i++) begin : g_sync
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          s1_q[i] <= 1'b0;
          s2_q[i] <= 1'b0;
          s3_q[i] <= 1'b0;
        end else begin
          s1_q[i] <= tif.conn_raw[i];
          s2_q[i] <= s1_q[i];
          s3_q[i] <= s2_q[i];
        end
      end
    end
  endgenerate
  // only the configured connector is heard [RULE6]
  always_comb begin
    tif.ext_event = tif.enable && s2_q[tif.conn_sel] && !s3_q[tif.conn_sel];
  end
endmodule

/* bench/ass_seq_checker.sv */
/* concurrent checks on the sequencer top ports.
   assumes binding onto ass_seq, whose port names it reuses. */
`timescale 1ns/100ps
module ass_seq_checker (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic sample_valid,
  input wire logic seg_begin_marker
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  sequence wr_both;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  chk_write_answer: assert property (wr_both |-> ##2 s_axi_bvalid)
    else $error("write answer not in time");
  chk_bresp_hold: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write answer dropped");
  chk_aw_blocked: assert property (
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while answering");
  chk_read_answer: assert property (rd_take |=> s_axi_rvalid)
    else $error("read answer not in time");
  chk_rdata_hold: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer changed");
  chk_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answering");
  chk_start_marker: assert property (
    $rose(sample_valid) |-> seg_begin_marker)
    else $error("no marker at playback start");
  chk_marker_play: assert property (
    seg_begin_marker |-> sample_valid)
    else $error("marker while not playing");
endmodule

bind ass_seq ass_seq_checker u_ass_seq_checker (.*);

/* bench/ass_trig_src.sv */
/* external trigger source on the two user connectors.
   assumes a new request only after the previous pulse has ended. */
`timescale 1ns/100ps
module ass_trig_src (
  input wire logic aclk,
  input wire logic fire,
  input wire logic pin,
  input wire logic slow,
  output logic [1:0] user_conn
);
  int cnt = 0;
  logic p = 1'b0;
  initial user_conn = 2'b00;
  always @(posedge aclk) begin
    if (fire && cnt == 0) begin
      p <= pin;
      user_conn[pin] <= 1'b1;
      cnt <= slow ? 12 : 6;
    end else if (cnt > 0) begin
      cnt <= cnt - 1;
      if (cnt == (slow ? 6 : 3)) user_conn[p] <= 1'b0;
    end
  end
endmodule

/* bench/ass_seq_bench.sv */
/* self-checking bench of the segment sequencer against a reference model.
   assumes ass_pkg, ass_seq, the checker and the trigger source. */
`timescale 1ns/100ps
module ass_seq_bench;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [11:0] s_axi_awaddr = '0;
  logic [11:0] s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, sample_valid, seg_begin_marker;
  logic [1:0] s_axi_bresp, s_axi_rresp, user_conn, r;
  logic [31:0] s_axi_rdata, sample_addr, mark_addr, ctl, d;
  logic fire = 1'b0;
  logic pin = 1'b0;
  logic slow = 1'b0;
  logic play = 1'b0;
  logic [31:0] st [3];
  logic [7:0] fid [3];
  int cur, k, nseg, pllen, cycles, mismatches, comparisons;
  int plist [$];
  ass_seq u_ass_seq (.*);
  ass_trig_src u_ass_trig_src (.*);
  initial forever #4 aclk = ~aclk;
  always @(posedge aclk) if (seg_begin_marker) mark_addr <= sample_addr;
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      give_verdict();
    end
  end
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected %s: expected %h, seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!(s_axi_bvalid && s_axi_bready));
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!(s_axi_rvalid && s_axi_rready));
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic setc(input logic [31:0] v);
    ctl = v;
    wr(12'h000, v);
  endtask
  task automatic cmd(input int b);
    wr(12'h00c, 32'(1) << b);
  endtask
  task automatic stat(input logic pend);
    repeat (3) @(posedge aclk);
    rd(12'h010);
    chk("status", {12'h000, ctl[1] && nseg > 1 && pllen != 0, pend, play,
      1'b0, fid[cur], 4'h0, 4'(cur)}, d);
    chk("marker address", st[cur], mark_addr);
  endtask
  task automatic trig(input logic p, input logic s);
    @(posedge aclk);
    fire <= 1'b1;
    pin <= p;
    slow <= s;
    @(posedge aclk);
    fire <= 1'b0;
    repeat (20) @(posedge aclk);
  endtask
  initial begin
    k = $urandom(32'hd989);
    nseg = 3;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(12'h000);
    chk("control reset", 32'h0000_0000, d);
    rd(12'h0fc);
    chk("read response", 32'(2'b10), 32'(r));
    wr(12'h0fc, 32'h0000_0001);
    chk("write response", 32'(2'b10), 32'(r));
    for (int i = 0; i < 3; i++) begin
      st[i] = 32'(i + 1) << 16;
      fid[i] = 8'($urandom);
      wr(12'(12'h100 + 16 * i), st[i]);
      wr(12'(12'h104 + 16 * i), 32'h0000_00c8);
      wr(12'(12'h108 + 16 * i), 32'(fid[i]));
    end
    wr(12'h014, 32'h0000_0003);
    setc(32'h0000_0003);
    cmd(1);
    play = 1'b1;
    stat(1'b0);
    repeat (4) begin
      cmd(0);
      cur = (cur + 1) % nseg;
      stat(1'b0);
    end
    $display("test internal order done");
    k = (cur + 1 + $urandom % 2) % nseg;
    wr(12'h004, 32'(k));
    cur = k;
    stat(1'b0);
    setc(32'h0000_0013);
    k = (cur + 2) % nseg;
    wr(12'h008, 32'(k));
    cmd(0);
    cur = k;
    stat(1'b0);
    k = (cur + 2) % nseg;
    plist = {k, k, k};
    foreach (plist[j]) wr(12'(12'h200 + 4 * j), 32'(plist[j]));
    wr(12'h018, 32'(plist.size()));
    pllen = plist.size();
    setc(32'h0000_0023);
    cmd(0);
    cur = plist[0];
    stat(1'b0);
    $display("test selection done");
    setc(32'h0000_0047);
    trig(1'b0, 1'b0);
    stat(1'b0);
    trig(1'b1, 1'b1);
    cur = (cur + 1) % nseg;
    stat(1'b0);
    $display("test external done");
    setc(32'h0000_0002);
    // unloading the file ends playback
    play = 1'b0;
    cmd(0);
    stat(1'b0);
    setc(32'h0000_0001);
    stat(1'b0);
    setc(32'h0000_0003);
    wr(12'h014, 32'h0000_0001);
    nseg = 1;
    stat(1'b0);
    wr(12'h014, 32'h0000_0003);
    nseg = 3;
    $display("test gating done");
    cmd(1);
    cur = 0;
    play = 1'b1;
    cmd(0);
    cur = (cur + 1) % nseg;
    setc(32'h0000_009b);
    wr(12'h008, 32'((cur + 1) % nseg));
    cmd(0);
    k = (cur + 2) % nseg;
    wr(12'h008, 32'(k));
    cmd(0);
    stat(1'b1);
    repeat (250) @(posedge aclk);
    cur = k;
    stat(1'b0);
    setc(32'h0000_001b);
    k = (cur + 1) % nseg;
    wr(12'h008, 32'(k));
    cmd(0);
    cur = k;
    stat(1'b0);
    cmd(2);
    play = 1'b0;
    stat(1'b0);
    chk("sample valid", 32'(1'b0), 32'(sample_valid));
    $display("test transitions done");
    give_verdict();
  end
endmodule
